// ---- core/sbsc_top.sv ----
// Stepper bridge switch control: pin inputs, step counter, chopping, two bridges, APB.
// Assumes pins are asynchronous to pclk and pass a three-stage synchroniser.
// Operation
// - forward current patterns for charge, slow, fast.
// - reverse current patterns for charge, slow, fast.
// - dead time between every pattern change.
// - decay uses active switches, not diodes.
// - disable forces all four switches off.
// - reset high: steps advance; enable gates outputs.
// - enable low: outputs off, counter still steps.
// - reset low: steps ignored, initial state held.
// - thermal trip switches all outputs off.
// - step in charge also resets chopping counter.
// - step resets counter at next oscillator edge.
// - reset low flags initial state; resume after.
// - enable gates output stage only.
// - open-drain protect low during thermal trip.
//
// Our own choices: the APB register port and the register addresses.
`include "sbsc_map.svh"
`default_nettype none
module sbsc_top
  import sbsc_pkg::*;
#(
  parameter int PHASE_W = 3,
  parameter int CHOP_W = 4,
  parameter int DEAD_CYC = `SBSC_DEAD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic step_clock,
  input wire logic reset_n_pin,
  input wire logic enable_pin,
  input wire logic chopping_oscillator,
  input wire logic thermal_trip,
  output logic [3:0] bridge_a,
  output logic [3:0] bridge_b,
  output logic initial_state_flag_o,
  output logic initial_state_flag_oe_n,
  output logic protect_o,
  output logic protect_oe_n,
  output logic irq
);
  // Three-stage synchronisers; stage 1 feeds only stage 2.
  logic [4:0] s1, s2, s3;
  logic [4:0] next_s1, next_s2, next_s3;
  logic [4:0] stable;
  logic [4:0] next_stable;
  logic stable_q_step, stable_q_osc, stable_q_trip;
  logic next_stable_q_step, next_stable_q_osc, next_stable_q_trip;
  always_comb begin
    next_s1 = {thermal_trip, chopping_oscillator, enable_pin, reset_n_pin, step_clock};
    next_s2 = s1;
    next_s3 = s2;
    next_stable = stable;
    for (int i = 0; i < 5; i++) begin
      if (s2[i] == s3[i]) next_stable[i] = s2[i];
    end
    next_stable_q_step = stable[0];
    next_stable_q_osc = stable[3];
    next_stable_q_trip = stable[4];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 5'h00;
      s2 <= 5'h00;
      s3 <= 5'h00;
      stable <= 5'h00;
      stable_q_step <= 1'b0;
      stable_q_osc <= 1'b0;
      stable_q_trip <= 1'b0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      stable <= next_stable;
      stable_q_step <= next_stable_q_step;
      stable_q_osc <= next_stable_q_osc;
      stable_q_trip <= next_stable_q_trip;
    end
  end
  logic run_n, en, trip, step_rise, osc_rise;
  assign run_n = stable[1];
  assign en = stable[2];
  assign trip = stable[4];
  assign step_rise = stable[0] && !stable_q_step;
  assign osc_rise = stable[3] && !stable_q_osc;

  // Software registers.
  logic [31:0] ctrl, next_ctrl;
  logic [`SBSC_IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic apb_wr, apb_rd;
  logic [31:0] next_prdata;
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  // Read data is loaded in the setup cycle so it already stands when the access is sampled.
  logic rd_setup;
  assign rd_setup = psel && !penable && !pwrite;

  // Excitation phase counter and chopping state.
  logic [PHASE_W-1:0] phase, next_phase;
  logic [CHOP_W-1:0] chop_cnt, next_chop_cnt;
  logic chop_pend, next_chop_pend;
  logic at_init, next_at_init;
  logic chop_wrap;
  sbsc_mode_t mode_a, mode_b;
  logic chop_ev;

  always_comb begin
    next_phase = phase;
    next_at_init = at_init;
    next_chop_pend = chop_pend;
    next_chop_cnt = chop_cnt;
    chop_wrap = 1'b0;
    if (!run_n) begin
      next_phase = '0;
      next_at_init = 1'b1;
      next_chop_pend = 1'b0;
    end else if (step_rise) begin
      // Advances regardless of enable so outputs resume in step.
      next_phase = phase + 1'b1;
      next_at_init = 1'b0;
      next_chop_pend = 1'b1;
    end
    if (osc_rise) begin
      if (chop_pend || !run_n) begin
        next_chop_cnt = '0;
        if (run_n && !step_rise) next_chop_pend = 1'b0;
      end else begin
        next_chop_cnt = chop_cnt + 1'b1;
        chop_wrap = (chop_cnt == '1);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= '0;
      at_init <= 1'b1;
      chop_pend <= 1'b0;
      chop_cnt <= '0;
    end else begin
      phase <= next_phase;
      at_init <= next_at_init;
      chop_pend <= next_chop_pend;
      chop_cnt <= next_chop_cnt;
    end
  end

  // Decay mode per phase: charge briefly after counter reset, then the programmed mode.
  function automatic sbsc_mode_t pick_mode(input logic [1:0] sel, input logic [CHOP_W-1:0] c);
    if (c == '0) pick_mode = SBSC_CHARGE;
    else if (sel == 2'b01) pick_mode = SBSC_SLOW;
    else if (sel == 2'b10) pick_mode = SBSC_FAST;
    else pick_mode = SBSC_CHARGE;
  endfunction : pick_mode
  assign mode_a = pick_mode(ctrl[`SBSC_CTRL_MA +: 2], chop_cnt);
  assign mode_b = pick_mode(ctrl[`SBSC_CTRL_MB +: 2], chop_cnt);

  logic force_off;
  assign force_off = trip || !en;
  logic rev_a, rev_b;
  assign rev_a = ctrl[`SBSC_CTRL_DIR_A] ^ phase[PHASE_W-1];
  assign rev_b = ctrl[`SBSC_CTRL_DIR_B] ^ (phase[PHASE_W-1] ^ phase[PHASE_W-2]);

  sbsc_bridge #(.DEAD_CYC(DEAD_CYC)) u_bridge_a (
    .pclk(pclk),
    .presetn(presetn),
    .mode(mode_a),
    .reverse(rev_a),
    .force_off(force_off),
    .upper_switch_left(bridge_a[3]),
    .upper_switch_right(bridge_a[2]),
    .lower_switch_left(bridge_a[1]),
    .lower_switch_right(bridge_a[0]),
    .in_dead()
  );
  sbsc_bridge #(.DEAD_CYC(DEAD_CYC)) u_bridge_b (
    .pclk(pclk),
    .presetn(presetn),
    .mode(mode_b),
    .reverse(rev_b),
    .force_off(force_off),
    .upper_switch_left(bridge_b[3]),
    .upper_switch_right(bridge_b[2]),
    .lower_switch_left(bridge_b[1]),
    .lower_switch_right(bridge_b[0]),
    .in_dead()
  );

  // Open-drain pins: thermal trip pulls protect low; the initial state pulls the flag low.
  assign protect_o = 1'b0;
  assign protect_oe_n = !trip;
  assign initial_state_flag_o = 1'b0;
  assign initial_state_flag_oe_n = !at_init;

  // Register bus and sticky events; a set in the clearing cycle survives.
  logic [`SBSC_IRQ_W-1:0] ev;
  assign chop_ev = chop_wrap;
  assign ev = {chop_ev, trip && !stable_q_trip, step_rise && run_n};
  logic [`SBSC_IRQ_W-1:0] reported;
  assign reported = prdata[`SBSC_IRQ_W-1:0];
  always_comb begin
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_prdata = prdata;
    if (apb_wr && paddr == `SBSC_OFF_CTRL) next_ctrl = pwdata;
    if (apb_wr && paddr == `SBSC_OFF_MASK) next_irq_mask = pwdata[`SBSC_IRQ_W-1:0];
    // Clearing only what was reported keeps an event that lands between setup and access.
    if (apb_rd && paddr == `SBSC_OFF_IRQ) begin
      next_irq_stat = irq_stat & ~reported;
    end
    if (rd_setup) begin
      case (paddr)
        `SBSC_OFF_CTRL: next_prdata = ctrl;
        `SBSC_OFF_STAT: next_prdata = {26'h0, at_init, trip, en, run_n, force_off, chop_pend};
        `SBSC_OFF_IRQ: next_prdata = {29'h0, irq_stat};
        `SBSC_OFF_MASK: next_prdata = {29'h0, irq_mask};
        `SBSC_OFF_PHASE: next_prdata = 32'(phase);
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    next_irq_stat = next_irq_stat | ev;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SBSC_CTRL_RST;
      irq_mask <= '0;
      irq_stat <= '0;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      prdata <= next_prdata;
    end
  end
  assign pslverr = 1'b0;
  assign irq = |(irq_stat & irq_mask);

  // Checks on what this level drives; each bridge carries its own switch checks.
  a_trip_off: assert property (@(posedge pclk) disable iff (!presetn)
    trip |-> ##2 (bridge_a == 4'h0 && bridge_b == 4'h0))
    else $error("bridges on during thermal trip");
  a_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !en |-> ##2 (bridge_a == 4'h0 && bridge_b == 4'h0))
    else $error("bridges on while disabled");
  a_step_advance: assert property (@(posedge pclk) disable iff (!presetn)
    (run_n && step_rise) |=> phase == $past(phase) + 1'b1)
    else $error("step did not advance phase");
  a_reset_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !run_n |=> (phase == '0 && at_init))
    else $error("phase moved while reset low");
  a_protect_pin: assert property (@(posedge pclk) disable iff (!presetn)
    protect_oe_n == !trip)
    else $error("protect pin disagrees with trip");
  a_chop_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (chop_pend && osc_rise) |=> chop_cnt == '0)
    else $error("chopping counter not restarted");
  a_charge_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (chop_pend && osc_rise) |=> (mode_a == SBSC_CHARGE && mode_b == SBSC_CHARGE))
    else $error("no charge after chopping restart");
  a_step_pending: assert property (@(posedge pclk) disable iff (!presetn)
    (run_n && step_rise) |=> chop_pend)
    else $error("step did not arm chopping restart");
  a_enable_step: assert property (@(posedge pclk) disable iff (!presetn)
    (!en && run_n && step_rise) |=> phase == $past(phase) + 1'b1)
    else $error("phase stopped while disabled");
  a_disable_next: assert property (@(posedge pclk) disable iff (!presetn)
    !en |=> (bridge_a == 4'h0 && bridge_b == 4'h0))
    else $error("switches on one cycle after disable");
  a_trip_next: assert property (@(posedge pclk) disable iff (!presetn)
    trip |=> (bridge_a == 4'h0 && bridge_b == 4'h0))
    else $error("switches on one cycle after trip");
  a_flag_low: assert property (@(posedge pclk) disable iff (!presetn)
    !run_n |=> !initial_state_flag_oe_n)
    else $error("initial flag not pulled low in reset");
  a_flag_release: assert property (@(posedge pclk) disable iff (!presetn)
    (run_n && step_rise) |=> initial_state_flag_oe_n)
    else $error("initial flag still low after a step");
  a_init_phase: assert property (@(posedge pclk) disable iff (!presetn)
    (at_init && run_n && step_rise) |=> (phase == PHASE_W'(1) && !at_init))
    else $error("first step did not leave the initial state");
  a_read_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && paddr == `SBSC_OFF_PHASE) |=> prdata == 32'($past(phase)))
    else $error("read data not ready for the access phase");
  a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (ev != '0) |=> (irq_stat & $past(ev)) == $past(ev))
    else $error("event lost from status");
  a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_rd && paddr == `SBSC_OFF_IRQ && ev == '0) |=> (irq_stat & $past(reported)) == '0)
    else $error("reported status bits not cleared by read");
endmodule : sbsc_top
`default_nettype wire

// ---- pkg/sbsc_map.svh ----
// Constant map for the stepper bridge switch control block.
// Assumes a 250 MHz pclk and an APB slave with 32-bit aligned words.
`ifndef SBSC_MAP_SVH
`define SBSC_MAP_SVH
`define SBSC_CLK_MHZ 250
`define SBSC_DEAD_NS 300
`define SBSC_DEAD_CYC ((`SBSC_DEAD_NS * `SBSC_CLK_MHZ + 999) / 1000)
`define SBSC_OFF_CTRL 12'h000
`define SBSC_OFF_STAT 12'h004
`define SBSC_OFF_IRQ 12'h008
`define SBSC_OFF_MASK 12'h00c
`define SBSC_OFF_PHASE 12'h010
`define SBSC_CTRL_RST 32'h0000_0000
`define SBSC_CTRL_DIR_A 0
`define SBSC_CTRL_DIR_B 1
`define SBSC_CTRL_MA 2
`define SBSC_CTRL_MB 4
`define SBSC_IRQ_STEP 0
`define SBSC_IRQ_TRIP 1
`define SBSC_IRQ_CHOP 2
`define SBSC_IRQ_W 3
`endif

// ---- pkg/sbsc_pkg.sv ----
// Types shared by the stepper bridge switch control block.
// Assumes sbsc_map.svh supplies the numeric constants.
`default_nettype none
package sbsc_pkg;
  typedef enum logic [1:0] {
    SBSC_CHARGE = 2'b00,
    SBSC_SLOW = 2'b01,
    SBSC_FAST = 2'b10,
    SBSC_OFF = 2'b11
  } sbsc_mode_t;
  typedef enum logic [1:0] {
    SBSC_RUN = 2'b00,
    SBSC_DEAD = 2'b01,
    SBSC_HALT = 2'b10
  } sbsc_dt_state_t;
endpackage : sbsc_pkg
`default_nettype wire

// ---- core/sbsc_bridge.sv ----
// One H-bridge: maps mode and direction to four switch gates with dead time.
// Assumes mode, direction and force_off are synchronous to pclk.
`include "sbsc_map.svh"
`default_nettype none
module sbsc_bridge
  import sbsc_pkg::*;
#(
  parameter int DEAD_CYC = `SBSC_DEAD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire sbsc_mode_t mode,
  input wire logic reverse,
  input wire logic force_off,
  output logic upper_switch_left,
  output logic upper_switch_right,
  output logic lower_switch_left,
  output logic lower_switch_right,
  output logic in_dead
);
  // Gate order is {upper_left, upper_right, lower_left, lower_right}.
  function automatic logic [3:0] gate_pattern(input sbsc_mode_t m, input logic rev);
    case (m)
      SBSC_CHARGE: gate_pattern = rev ? 4'h6 : 4'h9;
      SBSC_SLOW: gate_pattern = 4'h3;
      SBSC_FAST: gate_pattern = rev ? 4'h9 : 4'h6;
      default: gate_pattern = 4'h0;
    endcase
  endfunction : gate_pattern

  logic [3:0] gates;
  logic [3:0] next_gates;
  logic [3:0] cur_pat;
  logic [3:0] next_cur_pat;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  sbsc_dt_state_t st;
  sbsc_dt_state_t next_st;
  logic [3:0] want;

  always_comb begin
    want = gate_pattern(mode, reverse);
    next_gates = gates;
    next_cur_pat = cur_pat;
    next_cnt = cnt;
    next_st = st;
    case (st)
      SBSC_RUN: begin
        if (force_off) begin
          next_gates = 4'h0;
          next_cur_pat = 4'h0;
          next_st = SBSC_HALT;
        end else if (want != cur_pat) begin
          // Break before make: every switch opens before the new pattern closes.
          next_gates = 4'h0;
          next_cnt = 8'(DEAD_CYC - 1);
          next_st = SBSC_DEAD;
        end
      end
      SBSC_DEAD: begin
        next_gates = 4'h0;
        if (force_off) begin
          next_cur_pat = 4'h0;
          next_st = SBSC_HALT;
        end else if (cnt == 8'h00) begin
          next_gates = want;
          next_cur_pat = want;
          next_st = SBSC_RUN;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      SBSC_HALT: begin
        next_gates = 4'h0;
        if (!force_off) begin
          next_cnt = 8'(DEAD_CYC - 1);
          next_st = SBSC_DEAD;
        end
      end
      default: begin
        next_gates = 4'h0;
        next_st = SBSC_HALT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gates <= 4'h0;
      cur_pat <= 4'h0;
      cnt <= 8'h00;
      st <= SBSC_HALT;
    end else begin
      gates <= next_gates;
      cur_pat <= next_cur_pat;
      cnt <= next_cnt;
      st <= next_st;
    end
  end

  assign upper_switch_left = gates[3];
  assign upper_switch_right = gates[2];
  assign lower_switch_left = gates[1];
  assign lower_switch_right = gates[0];
  assign in_dead = (st == SBSC_DEAD);

  a_no_shoot_through: assert property (@(posedge pclk) disable iff (!presetn)
    !(gates[3] && gates[1]) && !(gates[2] && gates[0]))
    else $error("upper and lower switch of one leg both on");
  a_dead_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (gates != 4'h0 && $changed(gates)) |-> $past(gates) == 4'h0)
    else $error("pattern changed without an all-off gap");
  a_off_forced: assert property (@(posedge pclk) disable iff (!presetn)
    force_off |=> gates == 4'h0)
    else $error("switches on while forced off");
endmodule : sbsc_bridge
`default_nettype wire

// ---- testbench/sbsc_host.sv ----
// Host-side model: step, reset, enable, trip pins and the chopping oscillator.
// Assumes pclk comes from the bench; pins change just after rising edges.
`default_nettype none
module sbsc_host (
  input wire logic pclk,
  output logic step_clock,
  output logic reset_n_pin,
  output logic enable_pin,
  output logic chopping_oscillator,
  output logic thermal_trip
);
  timeunit 1ns;
  timeprecision 1ps;
  int osc_cnt = 0;
  assign chopping_oscillator = (osc_cnt < 20);
  always @(posedge pclk) begin
    osc_cnt <= (osc_cnt == 39) ? 0 : osc_cnt + 1;
  end
  initial begin
    step_clock = 1'b0;
    reset_n_pin = 1'b0;
    enable_pin = 1'b0;
    thermal_trip = 1'b0;
  end
  // The settle count stands in for both supply ramps.
  task automatic power_up(input int settle);
    repeat (settle) @(posedge pclk);
    reset_n_pin <= 1'b1;
    enable_pin <= 1'b1;
  endtask : power_up
  task automatic set_pins(input logic rst_n, input logic en, input logic trip);
    @(posedge pclk);
    reset_n_pin <= rst_n;
    enable_pin <= en;
    thermal_trip <= trip;
  endtask : set_pins
  // Pulses are wide so the three-stage synchroniser cannot miss them.
  task automatic steps(input int n);
    repeat (n) begin
      @(posedge pclk);
      step_clock <= 1'b1;
      repeat (8) @(posedge pclk);
      step_clock <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask : steps
endmodule : sbsc_host
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for sbsc_top: APB master, host pin model, gate monitor.
// Assumes an APB slave that may stretch the access; read data is taken at its ready edge.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEAD = 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, ph0;
  logic pready, pslverr, flag_o, flag_oe_n, prot_o, prot_oe_n, irq;
  wire step_clock, reset_n_pin, enable_pin, osc, trip;
  logic [3:0] bridge_a, bridge_b, old, fref, e;
  logic [1:0] m;
  logic d;
  int errors = 0;
  int checks_done = 0;
  int seed = 60029;
  int n;
  always #2 pclk = ~pclk;
  sbsc_host host (.pclk(pclk), .step_clock(step_clock), .reset_n_pin(reset_n_pin),
    .enable_pin(enable_pin), .chopping_oscillator(osc), .thermal_trip(trip));
  sbsc_top #(.DEAD_CYC(DEAD)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .step_clock(step_clock),
    .reset_n_pin(reset_n_pin), .enable_pin(enable_pin), .chopping_oscillator(osc),
    .thermal_trip(trip), .bridge_a(bridge_a), .bridge_b(bridge_b),
    .initial_state_flag_o(flag_o), .initial_state_flag_oe_n(flag_oe_n),
    .protect_o(prot_o), .protect_oe_n(prot_oe_n), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks=%0d mismatches=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
    if (k == 50) begin
      errors++;
      results();
    end
  endtask : apb
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask : cyc
  task automatic wait_ab(input logic [7:0] exp);
    int k;
    k = 0;
    while ({bridge_a, bridge_b} !== exp && k < 400) begin
      cyc(1);
      k++;
    end
    chk({bridge_a, bridge_b}, exp);
    if (k == 400)
      results();
  endtask : wait_ab
  // Counts all-off cycles between the old and the new pattern of bridge A.
  task automatic dead_meas(input logic [3:0] exp);
    int z, k;
    z = 0;
    k = 0;
    while (k < 400 && (bridge_a === old || bridge_a === 4'b0000)) begin
      if (bridge_a === 4'b0000)
        z++;
      cyc(1);
      k++;
    end
    chk(bridge_a, exp);
    chk(z, DEAD);
    if (k == 400)
      results();
  endtask : dead_meas
  function automatic logic shoot(input logic [3:0] g);
    return ((g & 4'b1010) == 4'b1010) || ((g & 4'b0101) == 4'b0101);
  endfunction : shoot
  function automatic logic [3:0] exp_a(input logic [1:0] md, input logic dr,
    input logic [3:0] f);
    logic [3:0] fast;
    fast = dr ? ~f : f;
    if (md == 2'b01)
      return 4'b0011;
    if (md == 2'b10)
      return fast;
    return ~fast;
  endfunction : exp_a
  always @(posedge pclk) begin
    if (presetn === 1'b1 && (shoot(bridge_a) || shoot(bridge_b)))
      chk(1, 0);
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk(rd, 32'h0000_0000);
    host.power_up(10);
    apb(1, 12'h00c, 32'h0000_0002);
    apb(1, 12'h000, 32'h0000_0014);
    wait_ab(8'h33);
    $display("slow decay done");
    apb(1, 12'h000, 32'h0000_0018);
    cyc(20);
    chk(bridge_a === 4'b0110 || bridge_a === 4'b1001, 1);
    fref = bridge_a;
    for (int i = 0; i < 12; i++) begin
      m = 2'($random(seed));
      d = 1'($random(seed));
      e = exp_a(m, d, fref);
      old = bridge_a;
      apb(1, 12'h000, {26'h0, 2'b01, m, 1'b0, d});
      if (e !== old)
        dead_meas(e);
      else
        chk(bridge_a, e);
    end
    $display("patterns done");
    apb(0, 12'h010, 0);
    ph0 = rd;
    host.set_pins(1, 0, 0);
    wait_ab(8'h00);
    n = 1 + ($random(seed) & 3);
    host.steps(n);
    cyc(8);
    apb(0, 12'h010, 0);
    chk(rd, (ph0 + n) & 32'h7);
    host.set_pins(1, 1, 0);
    cyc(20);
    chk(bridge_a !== 4'b0000, 1);
    $display("enable done");
    host.set_pins(0, 1, 0);
    cyc(8);
    chk(flag_oe_n, 0);
    chk(flag_o, 0);
    apb(0, 12'h010, 0);
    ph0 = rd;
    host.steps(2);
    apb(0, 12'h010, 0);
    chk(rd, ph0);
    host.set_pins(1, 1, 0);
    host.steps(1);
    cyc(8);
    apb(0, 12'h010, 0);
    chk(rd, (ph0 + 1) & 32'h7);
    chk(flag_oe_n, 1);
    $display("reset pin done");
    apb(0, 12'h008, 0);
    host.set_pins(1, 1, 1);
    wait_ab(8'h00);
    chk({prot_oe_n, prot_o, irq}, 3'b001);
    apb(0, 12'h004, 0);
    chk(rd & 32'h3e, 32'h1e);
    apb(1, 12'h000, 32'h0000_0014);
    cyc(10);
    chk({bridge_a, bridge_b}, 8'h00);
    host.set_pins(1, 1, 0);
    cyc(8);
    chk(prot_oe_n, 1);
    apb(0, 12'h008, 0);
    chk(rd & 32'h2, 32'h2);
    cyc(2);
    chk(irq, 0);
    apb(1, 12'h00c, 32'h0000_0000);
    host.set_pins(1, 1, 1);
    cyc(10);
    chk(irq, 0);
    apb(0, 12'h008, 0);
    chk(rd & 32'h2, 32'h2);
    host.set_pins(1, 1, 0);
    apb(0, 12'h0f0, 0);
    chk({rd, pslverr}, 33'h0);
    $display("trip and irq done");
    results();
  end
endmodule : testbench
`default_nettype wire
